// ==== include/csf_params.svh ====
`ifndef CSF_PARAMS_SVH
`define CSF_PARAMS_SVH

// Register offsets
`define CSF_ADDR_STATE_ONE   8'h0B
`define CSF_ADDR_STATE_TWO   8'h0C
`define CSF_ADDR_FAULT       8'h0D

// Charger state register one fields
`define CSF_S1_OVERVOLT      7
`define CSF_S1_VALID         6
`define CSF_S1_ILIM          5
`define CSF_S1_THERM         4
`define CSF_S1_DONE          3

// Low end shared by the charger state and battery level code fields
`define CSF_FIELD_LO         0
`define CSF_S1_CODE_HI       2

// Charger state register two fields
`define CSF_S2_THERM_HI      7
`define CSF_S2_THERM_LO      5
`define CSF_S2_UNUSED        4
`define CSF_S2_RECHARGE      3
`define CSF_S2_LEVEL_HI      2

// Fault register fields
`define CSF_F_SHORT          3
`define CSF_F_HOT_LO         1
`define CSF_F_HOT_HI         0
`define CSF_F_UNUSED_MASK    8'hF4

// Codes
`define CSF_CHG_COMPLETE     3'h4
`define CSF_ZERO8            8'h00

`endif

// ==== include/csf_pkg.sv ====
package csf_pkg;
  typedef logic [2:0] csf_code_t;
  typedef logic [7:0] csf_byte_t;
endpackage : csf_pkg

// ==== hw/csf_fault_bit.sv ====
`timescale 1ns/1ps
`include "csf_params.svh"

// =============================================
// One sticky fault flag, set wins over clear
module csf_fault_bit (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // Control
  input  wire logic set_pulse,
  input  wire logic clear_pulse,
  input  wire logic power_lost,
  // State
  output logic      flag_reg
);
  logic flag_next;

  assign flag_next = set_pulse ? 1'b1 :
                     (clear_pulse | power_lost) ? 1'b0 : flag_reg;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  a_set_wins: assert property ( // see (RL9)
    @(posedge sys_clk) disable iff (!reset_n)
    set_pulse |=> flag_reg)
    else $error("fault set lost");
  a_clear_works: assert property ( // see (RL12)
    @(posedge sys_clk) disable iff (!reset_n)
    (!set_pulse && (clear_pulse || power_lost)) |=> !flag_reg)
    else $error("fault clear ignored");
endmodule : csf_fault_bit

// ==== hw/csf_status_regs.sv ====
`timescale 1ns/1ps
`include "csf_params.svh"

// =============================================
// Charger status and fault register group
// Contract
// (RL1) Bits 7,6: overvoltage and valid input levels
// (RL2) Bit 5: input current limited flag
// (RL3) Bit 4: thermal limiting flag
// (RL4) Bit 3: charge done latches, survives recharge
// (RL5) Bits 2:0: charger state code
// (RL6) Second register 7:5: thermistor code
// (RL7) Recharge flag only when disabled and complete
// (RL8) Second register 2:0: battery level code
// (RL9) Fault bit 3: battery short, resets zero
// (RL10) Fault bit 1: lower die overheat
// (RL11) Fault bit 0: upper die overheat
// (RL12) Faults clear by power cycle or one
// (RL13) Status writes ignored, unused bits zero
module csf_status_regs (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // Register port from the serial bus slave
  input  wire logic [7:0]       reg_addr,
  input  wire logic             reg_wr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_rd,
  output logic [7:0]            reg_rdata,
  // Supply and limiting levels
  input  wire logic             input_overvoltage_flag,
  input  wire logic             input_valid_flag,
  input  wire logic             input_current_limited_flag,
  input  wire logic             thermal_limit_flag,
  // Charger core state
  input  wire logic             charge_cycle_end,
  input  wire logic [2:0]       charger_state_code,
  input  wire logic [2:0]       thermistor_state_code,
  input  wire logic [2:0]       battery_level_code,
  input  wire logic             auto_recharge_disable,
  input  wire logic             battery_below_recharge,
  // Fault events
  input  wire logic             battery_short_event,
  input  wire logic             die_overheat_lower_event,
  input  wire logic             die_overheat_upper_event,
  // Done and fault latches
  output logic                  charge_complete_latch,
  output logic                  battery_short_fault,
  output logic                  die_overheat_lower_fault,
  output logic                  die_overheat_upper_fault
);

  // =============================================
  // Decode
  logic                 sel_one;
  logic                 sel_two;
  logic                 sel_fault;
  logic                 fault_wr;
  logic                 power_lost;
  logic                 valid_seen_reg;
  logic                 recharge_needed_flag;
  csf_pkg::csf_byte_t   state_one;
  csf_pkg::csf_byte_t   state_two;
  csf_pkg::csf_byte_t   fault_flags;
  csf_pkg::csf_byte_t   rdata_next;
  logic                 done_next;

  assign sel_one   = (reg_addr == `CSF_ADDR_STATE_ONE);
  assign sel_two   = (reg_addr == `CSF_ADDR_STATE_TWO);
  assign sel_fault = (reg_addr == `CSF_ADDR_FAULT);
  // Only the fault register accepts writes
  assign fault_wr  = reg_wr & sel_fault; // see (RL13)

  // Power cycle: valid input falling after it was seen high
  assign power_lost = valid_seen_reg & ~input_valid_flag; // see (RL12)

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      valid_seen_reg <= 1'b0;
    end else begin
      valid_seen_reg <= input_valid_flag;
    end
  end

  // =============================================
  // Charge done latch
  // Set by the end of a charge cycle; only a power cycle or reset clears
  // it, so a battery sagging under the recharge threshold never does.
  assign done_next = charge_cycle_end ? 1'b1 :
                     power_lost ? 1'b0 : charge_complete_latch; // see (RL4)

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      charge_complete_latch <= 1'b0;
    end else begin
      charge_complete_latch <= done_next;
    end
  end

  // =============================================
  // Recharge indication
  assign recharge_needed_flag = auto_recharge_disable &
      (charger_state_code == `CSF_CHG_COMPLETE) &
      battery_below_recharge; // see (RL7)

  // =============================================
  // Fault flags
  csf_fault_bit u_short (
    .sys_clk     (sys_clk),
    .reset_n     (reset_n),
    .set_pulse   (battery_short_event),
    .clear_pulse (fault_wr & reg_wdata[`CSF_F_SHORT]),
    .power_lost  (power_lost),
    .flag_reg    (battery_short_fault)
  ); // see (RL9)

  csf_fault_bit u_hot_lo (
    .sys_clk     (sys_clk),
    .reset_n     (reset_n),
    .set_pulse   (die_overheat_lower_event),
    .clear_pulse (fault_wr & reg_wdata[`CSF_F_HOT_LO]),
    .power_lost  (power_lost),
    .flag_reg    (die_overheat_lower_fault)
  ); // see (RL10)

  csf_fault_bit u_hot_hi (
    .sys_clk     (sys_clk),
    .reset_n     (reset_n),
    .set_pulse   (die_overheat_upper_event),
    .clear_pulse (fault_wr & reg_wdata[`CSF_F_HOT_HI]),
    .power_lost  (power_lost),
    .flag_reg    (die_overheat_upper_fault)
  ); // see (RL11) (RL12)

  // =============================================
  // Read assembly
  assign state_one = {input_overvoltage_flag,      // see (RL1)
                      input_valid_flag,            // see (RL1)
                      input_current_limited_flag,  // see (RL2)
                      thermal_limit_flag,          // see (RL3)
                      charge_complete_latch,
                      charger_state_code};         // see (RL5)
  // Bit 4 unused, reads zero
  assign state_two = {thermistor_state_code,       // see (RL6)
                      1'b0,                        // see (RL13)
                      recharge_needed_flag,
                      battery_level_code};         // see (RL8)
  assign fault_flags = {4'h0, battery_short_fault, 1'b0,
                        die_overheat_lower_fault,
                        die_overheat_upper_fault}; // see (RL13)

  assign rdata_next = sel_one   ? state_one :
                      sel_two   ? state_two :
                      sel_fault ? fault_flags : `CSF_ZERO8;

  // Read data is held until the next read strobe
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= `CSF_ZERO8;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

  // =============================================
  // Checks
  // Read-back checks compare with the levels one edge earlier, because
  // the read data register captures them at the strobe edge.
  a_overvolt_bit: assert property ( // see (RL1)
    @(posedge sys_clk) disable iff (!reset_n)
    (reg_rd && sel_one) |=>
      reg_rdata[`CSF_S1_OVERVOLT] == $past(input_overvoltage_flag) &&
      reg_rdata[`CSF_S1_VALID] == $past(input_valid_flag))
    else $error("supply bits wrong");

  a_ilim_bit: assert property ( // see (RL2)
    @(posedge sys_clk) disable iff (!reset_n)
    (reg_rd && sel_one) |=>
      reg_rdata[`CSF_S1_ILIM] == $past(input_current_limited_flag))
    else $error("current limit bit wrong");

  a_therm_bit: assert property ( // see (RL3)
    @(posedge sys_clk) disable iff (!reset_n)
    (reg_rd && sel_one) |=>
      reg_rdata[`CSF_S1_THERM] == $past(thermal_limit_flag))
    else $error("thermal bit wrong");

  a_done_sets: assert property ( // see (RL4)
    @(posedge sys_clk) disable iff (!reset_n)
    charge_cycle_end |=> charge_complete_latch)
    else $error("done latch not set");

  a_done_holds: assert property ( // see (RL4)
    @(posedge sys_clk) disable iff (!reset_n)
    (charge_complete_latch && !power_lost) |=> charge_complete_latch)
    else $error("done latch dropped");

  a_done_readback: assert property ( // see (RL4)
    @(posedge sys_clk) disable iff (!reset_n)
    (reg_rd && sel_one) |=>
      reg_rdata[`CSF_S1_DONE] == $past(charge_complete_latch))
    else $error("done bit wrong");

  a_state_code: assert property ( // see (RL5)
    @(posedge sys_clk) disable iff (!reset_n)
    (reg_rd && sel_one) |=>
      reg_rdata[`CSF_S1_CODE_HI:`CSF_FIELD_LO] == $past(charger_state_code))
    else $error("charger code wrong");

  a_therm_code: assert property ( // see (RL6)
    @(posedge sys_clk) disable iff (!reset_n)
    (reg_rd && sel_two) |=>
      reg_rdata[`CSF_S2_THERM_HI:`CSF_S2_THERM_LO] ==
        $past(thermistor_state_code) &&
      !reg_rdata[`CSF_S2_UNUSED])
    else $error("thermistor code wrong");

  a_recharge_gate: assert property ( // see (RL7)
    @(posedge sys_clk) disable iff (!reset_n)
    (reg_rd && sel_two && !auto_recharge_disable) |=>
      !reg_rdata[`CSF_S2_RECHARGE])
    else $error("recharge bit not gated");

  a_recharge_bit: assert property ( // see (RL7)
    @(posedge sys_clk) disable iff (!reset_n)
    (reg_rd && sel_two) |=>
      reg_rdata[`CSF_S2_RECHARGE] == $past(auto_recharge_disable &&
        charger_state_code == `CSF_CHG_COMPLETE && battery_below_recharge))
    else $error("recharge bit wrong");

  a_level_code: assert property ( // see (RL8)
    @(posedge sys_clk) disable iff (!reset_n)
    (reg_rd && sel_two) |=>
      reg_rdata[`CSF_S2_LEVEL_HI:`CSF_FIELD_LO] == $past(battery_level_code))
    else $error("battery code wrong");

  a_short_set: assert property ( // see (RL9)
    @(posedge sys_clk) disable iff (!reset_n)
    battery_short_event |=> battery_short_fault)
    else $error("short fault lost");

  a_short_clear: assert property ( // see (RL9)
    @(posedge sys_clk) disable iff (!reset_n)
    (fault_wr && reg_wdata[`CSF_F_SHORT] && !battery_short_event) |=>
      !battery_short_fault)
    else $error("short fault not cleared");

  a_hot_lo_set: assert property ( // see (RL10)
    @(posedge sys_clk) disable iff (!reset_n)
    die_overheat_lower_event |=> die_overheat_lower_fault)
    else $error("lower overheat lost");

  a_hot_lo_clear: assert property ( // see (RL12)
    @(posedge sys_clk) disable iff (!reset_n)
    (fault_wr && reg_wdata[`CSF_F_HOT_LO] && !die_overheat_lower_event)
      |=> !die_overheat_lower_fault)
    else $error("lower overheat not cleared");

  a_hot_hi_set: assert property ( // see (RL11)
    @(posedge sys_clk) disable iff (!reset_n)
    die_overheat_upper_event |=> die_overheat_upper_fault)
    else $error("upper overheat lost");

  a_hot_hi_clear: assert property ( // see (RL12)
    @(posedge sys_clk) disable iff (!reset_n)
    (fault_wr && reg_wdata[`CSF_F_HOT_HI] && !die_overheat_upper_event)
      |=> !die_overheat_upper_fault)
    else $error("upper overheat not cleared");

  a_power_clear: assert property ( // see (RL12)
    @(posedge sys_clk) disable iff (!reset_n)
    (power_lost && !battery_short_event) |=> !battery_short_fault)
    else $error("power cycle kept fault");

  a_unmapped_zero: assert property ( // see (RL13)
    @(posedge sys_clk) disable iff (!reset_n)
    (reg_rd && !sel_one && !sel_two && !sel_fault) |=> reg_rdata == `CSF_ZERO8)
    else $error("unmapped read nonzero");

  // A write aimed at a status register must never reach the fault flags
  a_ro_write_kept: assert property ( // see (RL13)
    @(posedge sys_clk) disable iff (!reset_n)
    (reg_wr && !sel_fault && !power_lost && battery_short_fault) |=>
      battery_short_fault)
    else $error("status write touched fault");

  a_fault_unused: assert property ( // see (RL13)
    @(posedge sys_clk) disable iff (!reset_n)
    (reg_rd && sel_fault) |=>
      (reg_rdata & `CSF_F_UNUSED_MASK) == `CSF_ZERO8)
    else $error("unused fault bits nonzero");

  // Main scenarios the bench is expected to reach
  c_done: cover property (@(posedge sys_clk) disable iff (!reset_n)
    charge_cycle_end ##1 charge_complete_latch);
  c_fault_clear: cover property (@(posedge sys_clk) disable iff (!reset_n)
    battery_short_fault ##1 fault_wr ##1 !battery_short_fault);
  c_hot_hi_clear: cover property (@(posedge sys_clk) disable iff (!reset_n)
    die_overheat_upper_fault ##1 (fault_wr && reg_wdata[`CSF_F_HOT_HI])
    ##1 !die_overheat_upper_fault);
  c_recharge: cover property (@(posedge sys_clk) disable iff (!reset_n)
    recharge_needed_flag);
  c_power: cover property (@(posedge sys_clk) disable iff (!reset_n)
    power_lost);

endmodule : csf_status_regs

// ==== tb/csf_host_model.sv ====
`timescale 1ns/1ps
// =============================================
// Host side of the register port
module csf_host_model (
  // Clock
  input  wire logic       sys_clk,
  // Register port
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end
  // Idle lines show the inverse of the last value, never a stale copy
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    #1;
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~addr;
    reg_wdata = ~data;
  endtask : write_reg
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    @(posedge sys_clk);
    #1;
    reg_addr = addr;
    reg_rd   = 1'b1;
    @(posedge sys_clk);
    #1;
    data     = reg_rdata;
    reg_rd   = 1'b0;
    reg_addr = ~addr;
  endtask : read_reg
endmodule : csf_host_model

// ==== tb/csf_status_regs_bench.sv ====
`timescale 1ns/1ps
// =============================================
// Bench for the status and fault register group
module csf_status_regs_bench;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd;
  logic input_overvoltage_flag = 1'b0, input_valid_flag = 1'b0;
  logic input_current_limited_flag = 1'b0, thermal_limit_flag = 1'b0;
  logic charge_cycle_end = 1'b0, auto_recharge_disable = 1'b0;
  logic battery_below_recharge = 1'b0, battery_short_event = 1'b0;
  logic die_overheat_lower_event = 1'b0, die_overheat_upper_event = 1'b0;
  logic [2:0] charger_state_code = 3'h0, thermistor_state_code = 3'h0;
  logic [2:0] battery_level_code = 3'h0, c;
  logic charge_complete_latch, battery_short_fault;
  logic die_overheat_lower_fault, die_overheat_upper_fault;
  int num_errors = 0;
  int checks = 0;
  logic [7:0] e;
  // Pin view of the latches, laid out as done, short, lower, upper
  wire [7:0] pin_flags = {4'h0, charge_complete_latch, battery_short_fault,
                          die_overheat_lower_fault, die_overheat_upper_fault};

  always #12.5 sys_clk = ~sys_clk;

  csf_host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  csf_status_regs dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .input_overvoltage_flag(input_overvoltage_flag),
    .input_valid_flag(input_valid_flag),
    .input_current_limited_flag(input_current_limited_flag),
    .thermal_limit_flag(thermal_limit_flag),
    .charge_cycle_end(charge_cycle_end),
    .charger_state_code(charger_state_code),
    .thermistor_state_code(thermistor_state_code),
    .battery_level_code(battery_level_code),
    .auto_recharge_disable(auto_recharge_disable),
    .battery_below_recharge(battery_below_recharge),
    .battery_short_event(battery_short_event),
    .die_overheat_lower_event(die_overheat_lower_event),
    .die_overheat_upper_event(die_overheat_upper_event),
    .charge_complete_latch(charge_complete_latch),
    .battery_short_fault(battery_short_fault),
    .die_overheat_lower_fault(die_overheat_lower_fault),
    .die_overheat_upper_fault(die_overheat_upper_fault));

  task automatic check(input csf_pkg::csf_byte_t seen,
                       input csf_pkg::csf_byte_t exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic look(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] got;
    host.read_reg(addr, got);
    check(got, exp);
  endtask : look
  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  // Watchdog: the whole sequence needs far fewer cycles
  initial begin
    repeat (4000) @(posedge sys_clk);
    num_errors++;
    complete_run();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    look(8'h0D, 8'h00);
    look(8'h0B, 8'h00);
    input_valid_flag = 1'b1;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      charger_state_code = c;
      input_overvoltage_flag = c[0];
      input_current_limited_flag = c[1];
      thermal_limit_flag = c[2];
      e = {c[0], 1'b1, c[1], c[2], 1'b0, c};
      look(8'h0B, e);
    end
    {input_overvoltage_flag, input_current_limited_flag} = 2'b00;
    thermal_limit_flag = 1'b0;
    auto_recharge_disable = 1'b1;
    battery_below_recharge = 1'b1;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      {charger_state_code, thermistor_state_code, battery_level_code} = {3{c}};
      look(8'h0C, {c, 1'b0, c == 3'h4, c});
    end
    {charger_state_code, thermistor_state_code} = {3'h4, 3'h7};
    battery_level_code = 3'h1;
    auto_recharge_disable = 1'b0;
    look(8'h0C, 8'hE1);
    auto_recharge_disable = 1'b1;
    battery_below_recharge = 1'b0;
    look(8'h0C, 8'hE1);
    charge_cycle_end = 1'b1;
    look(8'h0B, 8'h4C);
    charge_cycle_end = 1'b0;
    battery_below_recharge = 1'b1;
    look(8'h0B, 8'h4C);
    check(pin_flags, 8'h08);
    battery_short_event = 1'b1;
    die_overheat_lower_event = 1'b1;
    die_overheat_upper_event = 1'b1;
    look(8'h0D, 8'h0B);
    {battery_short_event, die_overheat_lower_event} = 2'b00;
    die_overheat_upper_event = 1'b0;
    look(8'h0D, 8'h0B);
    host.write_reg(8'h0D, 8'h01);
    look(8'h0D, 8'h0A);
    check(pin_flags, 8'h0E);
    host.write_reg(8'h0D, 8'h0A);
    look(8'h0D, 8'h00);
    battery_short_event = 1'b1;
    host.write_reg(8'h0D, 8'h08);
    battery_short_event = 1'b0;
    look(8'h0D, 8'h08);
    host.write_reg(8'h0B, 8'hFF);
    host.write_reg(8'h0C, 8'hFF);
    host.write_reg(8'h20, 8'hFF);
    look(8'h0D, 8'h08);
    look(8'h0B, 8'h4C);
    look(8'h0C, 8'hE9);
    look(8'h20, 8'h00);
    input_valid_flag = 1'b0;
    look(8'h0D, 8'h00);
    check(pin_flags, 8'h00);
    complete_run();
  end
endmodule : csf_status_regs_bench
